// file: hw/qhm_fifo.v
// Synchronous FIFO holding assembled write words on their way to memory.
`timescale 1ns/10ps
`default_nettype none

module qhm_fifo #(
	parameter W = 61,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire ref_clk,
	input wire srst,
	// Filling side.
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// Draining side.
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] store [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	wire push;
	wire pop;

	// Full when the pointers differ only in the wrap bit.
	assign in_ready = (wr_ptr_reg != {~rd_ptr_reg[AW], rd_ptr_reg[AW-1:0]});
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign out_data = store[rd_ptr_reg[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Entry storage; no reset, only the pointers say what is valid.
	always @(posedge ref_clk) begin
		if (push) begin
			store[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointer update.
	always @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// file: hw/qhm_host_port.v
// Slave-side transaction logic of the quad-capable SPI host memory port.
// Summary of operation
// - Host reaches up to 2 GB space only through read, write, command frames.
// - Device returns 0x00 while busy, then 0x01, then read data bytes.
// - Quad mode burst reads continue only for DRAM targets.
// - Burst read enabled after reset; a configuration input turns it off.
// - Burst read auto-increments address and prefetches the next word.
// - Prefetched word is dropped silently when select rises.
// - Illegal read address returns 0xDEADABBA instead of data.
// - Without burst, the same word repeats until select rises.
// - Quad mode burst writes continue only for DRAM targets.
// - Burst write always on; address advances per word while select low.
// - Writes happen in whole words; a partial last word is dropped.
// - Host commands run only in single channel mode.
// - Configuration outputs reset only by the external reset.
// - Five 0x00 bytes in one frame form the wake command.
// - Select low starts a frame; high ends it; two clocks high between.
// - The two lowest address bits are ignored; accesses are word aligned.
// - All data pins return to input when select goes high.
`include "qhm_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module qhm_host_port #(
	parameter MEM_AW = 7,
	parameter REG_AW = 6,
	parameter FIFO_DEPTH = `QHM_FIFO_DEPTH,
	parameter FIFO_AW = 4
) (
	// Clock and reset.
	input wire ref_clk,
	input wire srst,
	// Serial link pins.
	input wire sck,
	input wire ss_n,
	input wire [3:0] io_in,
	output wire [3:0] io_out,
	output wire [3:0] io_oe_n,
	// Port setup from the configuration logic.
	input wire [1:0] chan_mode,
	input wire burst_rd_off,
	// Host command results.
	output wire host_cmd_stb,
	output wire [7:0] host_cmd_code,
	output wire [7:0] host_cmd_param,
	output wire wake_stb,
	// Write words lost because the write queue was full.
	output wire wr_drop
);

	// ------------------------------------------------------------------
	// State codes
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_RD = 3'h2;
	localparam [2:0] ST_WR = 3'h3;
	localparam [2:0] ST_CMD = 3'h4;
	localparam [2:0] ST_IGN = 3'h5;
	localparam FW = 29 + 32;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg [2:0] sck_sync_reg;
	reg [1:0] ss_sync_reg;
	reg [3:0] io_s1_reg;
	reg [3:0] io_s2_reg;
	reg [1:0] mode_reg;
	reg burst_en_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] sh_reg;
	reg byte_stb_reg;
	reg [7:0] rx_byte_reg;
	reg [2:0] state_reg;
	reg [2:0] byte_idx_reg;
	reg all_zero_reg;
	reg trail_ok_reg;
	reg [31:0] addr_reg;
	reg [28:0] rd_wa_reg;
	reg rd_dram_reg;
	reg fetch_want_reg;
	reg fetch_go_reg;
	reg fetch_cap_reg;
	reg fetch_ill_reg;
	reg [31:0] pre_reg;
	reg pre_vld_reg;
	reg [31:0] cur_reg;
	reg [2:0] tx_phase_reg;
	reg [7:0] tx_reg;
	reg [3:0] out_cnt_reg;
	reg [3:0] io_out_reg;
	reg [3:0] oe_n_reg;
	reg [28:0] wr_wa_reg;
	reg wr_dram_reg;
	reg wr_first_reg;
	reg [1:0] wb_idx_reg;
	reg [23:0] wr_acc_reg;
	reg push_reg;
	reg [FW-1:0] push_data_reg;
	reg drop_reg;
	reg cmd_stb_reg;
	reg [7:0] cmd_code_reg;
	reg [7:0] cmd_param_reg;
	reg wake_reg;
	reg [15:0] cmd_hold_reg;
	reg [7:0] sh_next;
	reg [3:0] step;
	reg [7:0] tx_next;
	wire frame_on;
	wire sck_rise;
	wire sck_fall;
	wire burst_ok;
	wire wr_more_ok;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [FW-1:0] fifo_out_data;
	wire [31:0] mem_rdata;
	wire load_byte;
	wire take_pre;

	// Word-address decode: register window, DRAM window, anything else illegal.
	function legal_wa;
		input [28:0] wa;
		begin
			legal_wa = wa[`QHM_DRAM_WA_BIT] | (wa[27:REG_AW] == {(28-REG_AW){1'b0}});
		end
	endfunction

	// The DRAM window aliases onto the upper half of the small memory model.
	function [MEM_AW-1:0] mem_index;
		input [28:0] wa;
		begin
			mem_index = {wa[`QHM_DRAM_WA_BIT], wa[MEM_AW-2:0]};
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------

	// Two flip-flops on every pin, a third on the link clock; its edge detection uses the second and third stages.
	always @(posedge ref_clk) begin
		if (srst) begin
			sck_sync_reg <= 3'h0;
			ss_sync_reg <= 2'h3;
			io_s1_reg <= 4'h0;
			io_s2_reg <= 4'h0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], sck};
			ss_sync_reg <= {ss_sync_reg[0], ss_n};
			io_s1_reg <= io_in;
			io_s2_reg <= io_s1_reg;
		end
	end

	// Edges count only inside a frame, so stray clocks while deselected are ignored.
	assign frame_on = ~ss_sync_reg[1];
	assign sck_rise = frame_on & sck_sync_reg[1] & ~sck_sync_reg[2];
	assign sck_fall = frame_on & ~sck_sync_reg[1] & sck_sync_reg[2];

	// Mode and burst enable are frozen for the whole frame.
	always @(posedge ref_clk) begin
		if (srst) begin
			mode_reg <= `QHM_MODE_SINGLE;
			burst_en_reg <= `QHM_BURST_EN_RST;
		end else if (!frame_on) begin
			mode_reg <= chan_mode;
			burst_en_reg <= ~burst_rd_off;
		end
	end

	// ------------------------------------------------------------------
	// Receive shifter
	// ------------------------------------------------------------------

	// Bits per clock and the shifted byte for the current mode.
	always @* begin
		case (mode_reg)
			`QHM_MODE_DUAL: begin
				step = 4'h2;
				sh_next = {sh_reg[5:0], io_s2_reg[1:0]};
			end
			`QHM_MODE_QUAD: begin
				step = 4'h4;
				sh_next = {sh_reg[3:0], io_s2_reg[3:0]};
			end
			default: begin
				step = 4'h1;
				sh_next = {sh_reg[6:0], io_s2_reg[0]};
			end
		endcase
	end

	// Sample on the rising clock edge and flag each complete byte.
	always @(posedge ref_clk) begin
		if (srst || !frame_on) begin
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			byte_stb_reg <= 1'b0;
			rx_byte_reg <= 8'h00;
		end else begin
			byte_stb_reg <= 1'b0;
			if (sck_rise) begin
				sh_reg <= sh_next;
				if (bit_cnt_reg + step == `QHM_BITS_PER_BYTE) begin
					bit_cnt_reg <= 4'h0;
					byte_stb_reg <= 1'b1;
					rx_byte_reg <= sh_next;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + step;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame decoder
	// ------------------------------------------------------------------

	// Quad mode allows bursts only against DRAM targets.
	assign burst_ok = burst_en_reg & ((mode_reg != `QHM_MODE_QUAD) | rd_dram_reg);
	assign wr_more_ok = (mode_reg != `QHM_MODE_QUAD) | wr_dram_reg;

	// Byte-level protocol; the frame state here clears when select rises.
	always @(posedge ref_clk) begin
		if (srst || !frame_on) begin
			// Configuration results and write staging survive select; only srst clears them.
			if (srst) begin
				cmd_code_reg <= 8'h00;
				cmd_param_reg <= 8'h00;
				cmd_hold_reg <= 16'h0000;
				wr_wa_reg <= 29'h0;
				wr_dram_reg <= 1'b0;
				wr_acc_reg <= 24'h0;
				push_data_reg <= {FW{1'b0}};
			end
			state_reg <= ST_IDLE;
			byte_idx_reg <= 3'h0;
			all_zero_reg <= 1'b1;
			trail_ok_reg <= 1'b1;
			addr_reg <= 32'h0;
			wb_idx_reg <= 2'h0;
			wr_first_reg <= 1'b1;
			push_reg <= 1'b0;
			wake_reg <= 1'b0;
			cmd_stb_reg <= 1'b0;
		end else begin
			push_reg <= 1'b0;
			wake_reg <= 1'b0;
			cmd_stb_reg <= 1'b0;
			if (byte_stb_reg) begin
				if (byte_idx_reg != 3'h7) begin
					byte_idx_reg <= byte_idx_reg + 3'h1;
				end
				all_zero_reg <= all_zero_reg & (rx_byte_reg == 8'h00);
				if (mode_reg == `QHM_MODE_SINGLE && all_zero_reg && rx_byte_reg == 8'h00 &&
						byte_idx_reg == `QHM_LAST_FRAME_IDX) begin
					wake_reg <= 1'b1;
				end
				case (state_reg)
					ST_IDLE: begin
						addr_reg <= {24'h0, rx_byte_reg};
						if (mode_reg == `QHM_MODE_SINGLE && rx_byte_reg == `QHM_CMD_LEAD) begin
							state_reg <= ST_CMD;
						end else begin
							state_reg <= ST_ADDR;
						end
					end
					ST_ADDR: begin
						addr_reg <= {addr_reg[23:0], rx_byte_reg};
						if (byte_idx_reg == `QHM_LAST_ADDR_IDX) begin
							// Low two address bits are dropped here.
							wr_wa_reg <= {addr_reg[22:0], rx_byte_reg[7:2]};
							wr_dram_reg <= addr_reg[22];
							if (addr_reg[16+`QHM_WR_FLAG_BIT]) begin
								state_reg <= ST_WR;
							end else begin
								state_reg <= ST_RD;
							end
						end
					end
					ST_CMD: begin
						if (byte_idx_reg == `QHM_CMD_CODE_IDX) begin
							cmd_hold_reg[15:8] <= rx_byte_reg;
						end
						if (byte_idx_reg == `QHM_CMD_PARAM_IDX) begin
							cmd_hold_reg[7:0] <= rx_byte_reg;
						end
						if (byte_idx_reg > `QHM_CMD_PARAM_IDX) begin
							trail_ok_reg <= trail_ok_reg & (rx_byte_reg == `QHM_CMD_TRAIL);
						end
						if (byte_idx_reg == `QHM_LAST_FRAME_IDX) begin
							cmd_stb_reg <= trail_ok_reg & (rx_byte_reg == `QHM_CMD_TRAIL);
							// Results move only with the strobe, so a cut frame leaves them alone.
							if (trail_ok_reg && rx_byte_reg == `QHM_CMD_TRAIL) begin
								cmd_code_reg <= cmd_hold_reg[15:8];
								cmd_param_reg <= cmd_hold_reg[7:0];
							end
							state_reg <= ST_IGN;
						end
					end
					ST_WR: begin
						// Bytes arrive LSB first; only a full word is pushed.
						wb_idx_reg <= wb_idx_reg + 2'h1;
						if (wb_idx_reg == 2'h3) begin
							push_reg <= legal_wa(wr_wa_reg) & (wr_first_reg | wr_more_ok);
							push_data_reg <= {wr_wa_reg, rx_byte_reg, wr_acc_reg};
							wr_wa_reg <= wr_wa_reg + 29'h1;
							wr_first_reg <= 1'b0;
						end else begin
							wr_acc_reg <= {rx_byte_reg, wr_acc_reg[23:8]};
						end
					end
					default: begin
						state_reg <= state_reg;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Read fetch and prefetch
	// ------------------------------------------------------------------

	// Fetches wait for the write queue to drain so reads see earlier writes.
	always @(posedge ref_clk) begin
		if (srst) begin
			rd_wa_reg <= 29'h0;
			rd_dram_reg <= 1'b0;
			fetch_want_reg <= 1'b0;
			fetch_go_reg <= 1'b0;
			fetch_cap_reg <= 1'b0;
			fetch_ill_reg <= 1'b0;
			pre_reg <= 32'h0;
			pre_vld_reg <= 1'b0;
		end else begin
			fetch_go_reg <= fetch_want_reg & ~fetch_go_reg & ~fetch_out_busy(fifo_out_valid);
			if (fetch_go_reg) begin
				fetch_want_reg <= 1'b0;
			end
			fetch_cap_reg <= fetch_go_reg;
			fetch_ill_reg <= ~legal_wa(rd_wa_reg);
			if (byte_stb_reg && state_reg == ST_ADDR && byte_idx_reg == `QHM_LAST_ADDR_IDX &&
					!addr_reg[16+`QHM_WR_FLAG_BIT]) begin
				rd_wa_reg <= {addr_reg[22:0], rx_byte_reg[7:2]};
				rd_dram_reg <= addr_reg[22];
				fetch_want_reg <= 1'b1;
			end else if (take_pre && burst_ok) begin
				rd_wa_reg <= rd_wa_reg + 29'h1;
				fetch_want_reg <= 1'b1;
			end
			if (!frame_on || state_reg != ST_RD) begin
				pre_vld_reg <= 1'b0;
			end else if (fetch_cap_reg) begin
				pre_reg <= fetch_ill_reg ? `QHM_ERR_WORD : mem_rdata;
				pre_vld_reg <= 1'b1;
			end else if (take_pre) begin
				pre_vld_reg <= 1'b0;
			end
			if (!frame_on) begin
				fetch_want_reg <= 1'b0;
			end
		end
	end

	// Read port is free only while the write queue holds nothing.
	function fetch_out_busy;
		input qv;
		begin
			fetch_out_busy = qv;
		end
	endfunction

	// ------------------------------------------------------------------
	// Transmit side
	// ------------------------------------------------------------------

	// A new byte is chosen on the falling edge that follows a finished byte.
	assign load_byte = sck_fall & (state_reg == ST_RD) & (out_cnt_reg == 4'h0);
	assign take_pre = load_byte & pre_vld_reg &
		((tx_phase_reg == 3'h0) | ((tx_phase_reg == 3'h4) & burst_ok));

	// Poll with 0x00, mark data with 0x01, then the word LSB first.
	always @* begin
		case (tx_phase_reg)
			3'h0: tx_next = pre_vld_reg ? `QHM_VALID_BYTE : `QHM_POLL_BYTE;
			3'h1: tx_next = cur_reg[7:0];
			3'h2: tx_next = cur_reg[15:8];
			3'h3: tx_next = cur_reg[23:16];
			3'h4: tx_next = cur_reg[31:24];
			default: tx_next = `QHM_POLL_BYTE;
		endcase
	end

	// Shift out on falling edges; the pins are driven only in the read phase.
	always @(posedge ref_clk) begin
		if (srst || !frame_on) begin
			tx_phase_reg <= 3'h0;
			tx_reg <= 8'h00;
			out_cnt_reg <= 4'h0;
			io_out_reg <= 4'h0;
			oe_n_reg <= `QHM_OE_N_IDLE;
			cur_reg <= 32'h0;
		end else begin
			if (state_reg != ST_RD) begin
				oe_n_reg <= `QHM_OE_N_IDLE;
			end else begin
				case (mode_reg)
					`QHM_MODE_DUAL: oe_n_reg <= 4'hc;
					`QHM_MODE_QUAD: oe_n_reg <= 4'h0;
					default: oe_n_reg <= 4'hd;
				endcase
			end
			if (load_byte) begin
				if (tx_phase_reg == 3'h0) begin
					if (pre_vld_reg) begin
						cur_reg <= pre_reg;
						tx_phase_reg <= 3'h1;
					end
				end else if (tx_phase_reg == 3'h4) begin
					// Repeat the word unless a burst has the next one waiting.
					tx_phase_reg <= 3'h1;
					if (take_pre) begin
						cur_reg <= pre_reg;
					end
				end else begin
					tx_phase_reg <= tx_phase_reg + 3'h1;
				end
			end
			if (sck_fall && state_reg == ST_RD) begin
				case (mode_reg)
					`QHM_MODE_DUAL: begin
						io_out_reg <= {2'h0, (load_byte ? tx_next[7:6] : tx_reg[7:6])};
						tx_reg <= load_byte ? {tx_next[5:0], 2'h0} : {tx_reg[5:0], 2'h0};
						out_cnt_reg <= load_byte ? 4'h6 : out_cnt_reg - 4'h2;
					end
					`QHM_MODE_QUAD: begin
						io_out_reg <= load_byte ? tx_next[7:4] : tx_reg[7:4];
						tx_reg <= load_byte ? {tx_next[3:0], 4'h0} : {tx_reg[3:0], 4'h0};
						out_cnt_reg <= load_byte ? 4'h4 : out_cnt_reg - 4'h4;
					end
					default: begin
						io_out_reg <= {2'h0, (load_byte ? tx_next[7] : tx_reg[7]), 1'b0};
						tx_reg <= load_byte ? {tx_next[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
						out_cnt_reg <= load_byte ? 4'h7 : out_cnt_reg - 4'h1;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Write queue and memory
	// ------------------------------------------------------------------

	// The serial link cannot be stalled, so a word meeting a full queue is counted lost.
	always @(posedge ref_clk) begin
		if (srst) begin
			drop_reg <= 1'b0;
		end else begin
			drop_reg <= push_reg & ~fifo_in_ready;
		end
	end

	qhm_fifo #(
		.W(FW),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(push_reg),
		.in_ready(fifo_in_ready),
		.in_data(push_data_reg),
		.out_valid(fifo_out_valid),
		.out_ready(~fetch_go_reg),
		.out_data(fifo_out_data)
	);

	qhm_mem #(
		.AW(MEM_AW),
		.W(32)
	) u_mem (
		.ref_clk(ref_clk),
		.srst(srst),
		.we(fifo_out_valid & ~fetch_go_reg),
		.waddr(mem_index(fifo_out_data[FW-1:32])),
		.wdata(fifo_out_data[31:0]),
		.re(fetch_go_reg & legal_wa(rd_wa_reg)),
		.raddr(mem_index(rd_wa_reg)),
		.rdata(mem_rdata)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign io_out = io_out_reg;
	assign io_oe_n = oe_n_reg;
	assign host_cmd_stb = cmd_stb_reg;
	assign host_cmd_code = cmd_code_reg;
	assign host_cmd_param = cmd_param_reg;
	assign wake_stb = wake_reg;
	assign wr_drop = drop_reg;

endmodule
`default_nettype wire

// file: hw/qhm_mem.v
// Word memory standing for the register and DRAM space behind the port.
`timescale 1ns/10ps
`default_nettype none

module qhm_mem #(
	parameter AW = 7,
	parameter W = 32
) (
	// Clock and reset.
	input wire ref_clk,
	input wire srst,
	// Write port.
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	// Read port, data one cycle after the strobe.
	input wire re,
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata
);

	reg [W-1:0] words [0:(1<<AW)-1];

	// Write side.
	always @(posedge ref_clk) begin
		if (we) begin
			words[waddr] <= wdata;
		end
	end

	// Registered read side.
	always @(posedge ref_clk) begin
		if (srst) begin
			rdata <= {W{1'b0}};
		end else if (re) begin
			rdata <= words[raddr];
		end
	end

endmodule
`default_nettype wire

// file: hw/qhm_unused_placeholder.v
// Empty: intentionally no content.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: include/qhm_defs.vh
// Shared constants for the quad-capable SPI host memory port.
`ifndef QHM_DEFS_VH
`define QHM_DEFS_VH

// ----------------------------------------------------------------------
// Channel modes
// ----------------------------------------------------------------------
`define QHM_MODE_SINGLE 2'h0
`define QHM_MODE_DUAL 2'h1
`define QHM_MODE_QUAD 2'h2

// ----------------------------------------------------------------------
// Protocol bytes and words
// ----------------------------------------------------------------------
`define QHM_POLL_BYTE 8'h00
`define QHM_VALID_BYTE 8'h01
`define QHM_CMD_LEAD 8'hff
`define QHM_CMD_TRAIL 8'h00
`define QHM_ERR_WORD 32'hdeadabba

// ----------------------------------------------------------------------
// Frame layout and field positions
// ----------------------------------------------------------------------
`define QHM_WR_FLAG_BIT 7
`define QHM_LAST_ADDR_IDX 3'h3
`define QHM_CMD_CODE_IDX 3'h1
`define QHM_CMD_PARAM_IDX 3'h2
`define QHM_LAST_FRAME_IDX 3'h4
`define QHM_DRAM_WA_BIT 28
`define QHM_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------------
// Reset values and queue depth
// ----------------------------------------------------------------------
`define QHM_BURST_EN_RST 1'b1
`define QHM_OE_N_IDLE 4'hf
`define QHM_FIFO_DEPTH 16

`endif

// file: sim/qhm_host_model.sv
// Host microcontroller model acting as link master, with pull-downs on the data lines.
`timescale 1ns/10ps
`default_nettype none

module qhm_host_model (
	// Link pins seen by the device.
	output logic sck,
	output logic ss_n,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	logic [3:0] hd = 4'h0;
	logic [3:0] hoe = 4'h0;
	int nb = 1;

	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
	end
	// Released lanes fall to the pull-down level, never to the last value.
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			io_in[k] = !io_oe_n[k] ? io_out[k] : (hoe[k] ? hd[k] : 1'b0);
		end
	end

	// One byte MSB first over nb lanes; the clock rests low outside bytes.
	task automatic xb(input logic [7:0] tx, input bit drv, output logic [7:0] rx);
		for (int i = 0; i < 8; i += nb) begin
			for (int j = 0; j < nb; j++) begin
				hd[j] = tx[7 - i - (nb - 1 - j)];
			end
			hoe = drv ? (4'hf >> (4 - nb)) : 4'h0;
			#20 sck = 1'b1;
			for (int j = 0; j < nb; j++) begin
				rx[7 - i - (nb - 1 - j)] = (nb == 1) ? io_in[1] : io_in[j];
			end
			#40 sck = 1'b0;
			#20;
		end
		hoe = 4'h0;
	endtask
	// The odd offset keeps link edges off the system clock edges.
	task automatic frame_start();
		#43.3 ss_n = 1'b0;
		#40;
	endtask
	// The gap is well over two link clocks.
	task automatic frame_end();
		#40 ss_n = 1'b1;
		#240;
	endtask
endmodule
`default_nettype wire

// file: sim/qhm_host_port_assertions.sv
// Concurrent checks on the pins of the host memory port.
`timescale 1ns/10ps
`default_nettype none
`include "qhm_defs.vh"

module qhm_host_port_chk (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Link pins and setup.
	input wire logic sck,
	input wire logic ss_n,
	input wire logic [3:0] io_oe_n,
	input wire logic [1:0] chan_mode,
	// Command results.
	input wire logic host_cmd_stb,
	input wire logic [7:0] host_cmd_code,
	input wire logic [7:0] host_cmd_param,
	input wire logic wake_stb
);
	logic sck_d1_reg;
	logic sck_d2_reg;
	logic ss_d1_reg;
	logic ss_d2_reg;
	logic [5:0] rises_reg;
	logic [5:0] addr_len;

	// Clock rises in the frame; saturating so a long burst never wraps under the address.
	// Cleared late enough that the pins are already released when it drops.
	always_ff @(posedge ref_clk) begin
		sck_d1_reg <= sck;
		sck_d2_reg <= sck_d1_reg;
		ss_d1_reg <= ss_n;
		ss_d2_reg <= ss_d1_reg;
		if (srst || ss_d2_reg) begin
			rises_reg <= 6'h00;
		end else if (sck_d1_reg && !sck_d2_reg && rises_reg != 6'h3f) begin
			rises_reg <= rises_reg + 6'h01;
		end
	end
	// Clocks taken by the four address bytes in each channel mode.
	assign addr_len = (chan_mode == `QHM_MODE_SINGLE) ? 6'h20 :
		(chan_mode == `QHM_MODE_DUAL) ? 6'h10 : 6'h08;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_idle;
		ss_n [*6];
	endsequence
	sequence s_pins_free;
		##[0:6] (io_oe_n == `QHM_OE_N_IDLE);
	endsequence

	a_oe_idle: assert property (s_idle |-> io_oe_n == `QHM_OE_N_IDLE)
		else $error("pins driven while deselected");
	a_oe_release: assert property ($rose(ss_n) |-> s_pins_free)
		else $error("pins not released after select rose");
	a_no_early: assert property (io_oe_n != 4'hf |-> rises_reg >= addr_len)
		else $error("pins driven before address complete");
	a_oe_lanes: assert property (io_oe_n != 4'hf |-> io_oe_n == (chan_mode == 2'h0 ? 4'hd :
		chan_mode == 2'h1 ? 4'hc : 4'h0))
		else $error("wrong lanes driven");
	a_cmd_pulse: assert property (host_cmd_stb |=> !host_cmd_stb)
		else $error("command strobe too long");
	a_wake_pulse: assert property (wake_stb |=> !wake_stb)
		else $error("wake strobe too long");
	a_code_hold: assert property (!host_cmd_stb |-> $stable(host_cmd_code) && $stable(host_cmd_param))
		else $error("command result changed without strobe");
	a_cmd_single: assert property (host_cmd_stb || wake_stb |-> chan_mode == `QHM_MODE_SINGLE)
		else $error("command taken outside single mode");
endmodule

bind qhm_host_port qhm_host_port_chk chk_i (.ref_clk(ref_clk), .srst(srst), .sck(sck), .ss_n(ss_n),
	.io_oe_n(io_oe_n), .chan_mode(chan_mode), .host_cmd_stb(host_cmd_stb),
	.host_cmd_code(host_cmd_code), .host_cmd_param(host_cmd_param), .wake_stb(wake_stb));
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the host memory port.
`timescale 1ns/10ps
`default_nettype none
`include "qhm_defs.vh"

module tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [1:0] chan_mode = 2'h0;
	logic burst_rd_off = 1'b0;
	wire sck, ss_n, host_cmd_stb, wake_stb, wr_drop;
	wire [3:0] io_in, io_out, io_oe_n;
	wire [7:0] host_cmd_code, host_cmd_param;
	int n_fail = 0;
	int samples_checked = 0;
	int n_cmd = 0;
	int n_wake = 0;
	int n_drop = 0;
	int cycles = 0;
	logic [31:0] got[$];

	always #5 ref_clk = ~ref_clk;
	qhm_host_port dut (.ref_clk(ref_clk), .srst(srst), .sck(sck), .ss_n(ss_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .chan_mode(chan_mode), .burst_rd_off(burst_rd_off),
		.host_cmd_stb(host_cmd_stb), .host_cmd_code(host_cmd_code),
		.host_cmd_param(host_cmd_param), .wake_stb(wake_stb), .wr_drop(wr_drop));
	qhm_host_model hm (.sck(sck), .ss_n(ss_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));

	// Strobe counting and the hang limit.
	always @(posedge ref_clk) begin
		cycles++;
		if (host_cmd_stb === 1'b1) n_cmd++;
		if (wake_stb === 1'b1) n_wake++;
		if (wr_drop === 1'b1) n_drop++;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic set_mode(input logic [1:0] m, input logic off);
		@(posedge ref_clk) #1;
		chan_mode = m;
		burst_rd_off = off;
		hm.nb = (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
	endtask
	task automatic send5(input logic [7:0] b0, b1, b2, b3, b4);
		logic [7:0] r;
		hm.frame_start();
		hm.xb(b0, 1'b1, r);
		hm.xb(b1, 1'b1, r);
		hm.xb(b2, 1'b1, r);
		hm.xb(b3, 1'b1, r);
		hm.xb(b4, 1'b1, r);
	endtask
	// Write nw words, then tail stray bytes that must not land.
	task automatic wr(input logic [31:0] a, w0, w1, input int nw, tail);
		logic [7:0] r;
		logic [31:0] w;
		send5(a[31:24] | 8'h80, a[23:16], a[15:8], a[7:0], w0[7:0]);
		for (int i = 0; i < nw * 4 + tail - 1; i++) begin
			w = (i < 3) ? w0 >> (8 * (i + 1)) : w1 >> (8 * (i - 3));
			hm.xb(w[7:0], 1'b1, r);
		end
		hm.frame_end();
	endtask
	// Read n words after polling for the valid byte.
	task automatic rd(input logic [31:0] a, input int n);
		logic [7:0] r;
		logic [31:0] w;
		int polls;
		got.delete();
		hm.frame_start();
		for (int k = 3; k >= 0; k--) hm.xb(a[8*k+:8], 1'b1, r);
		polls = 0;
		r = 8'h00;
		while (r !== 8'h01 && polls < 40) begin
			hm.xb(8'h00, 1'b0, r);
			if (r !== 8'h01) chk("poll byte", 32'h0, {24'h0, r});
			polls++;
		end
		chk("valid byte", 32'h1, {24'h0, r});
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 4; k++) begin
				hm.xb(8'h00, 1'b0, r);
				w[8*k+:8] = r;
			end
			got.push_back(w);
		end
		hm.frame_end();
	endtask

	task automatic t_write_read();
		wr(32'h18, 32'hc0ffee11, 0, 1, 0);
		wr(32'h13, 32'h12345678, 32'h9abcdef0, 2, 2);
		rd(32'h10, 3);
		chk("word0", 32'h12345678, got[0]);
		chk("word1", 32'h9abcdef0, got[1]);
		chk("word2", 32'hc0ffee11, got[2]);
		$display("write_read done");
	endtask
	task automatic t_burst_off();
		set_mode(2'h0, 1'b1);
		rd(32'h10, 2);
		chk("repeat", 32'h12345678, got[1]);
		set_mode(2'h0, 1'b0);
		rd(32'h1000, 1);
		chk("error word", `QHM_ERR_WORD, got[0]);
		$display("burst_off done");
	endtask
	task automatic t_commands();
		send5(8'hff, 8'h42, 8'h5a, 8'h00, 8'h00);
		hm.frame_end();
		chk("cmd count", 32'h1, n_cmd);
		chk("cmd code", 32'h425a, {host_cmd_code, host_cmd_param});
		send5(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		hm.frame_end();
		chk("wake count", 32'h1, n_wake);
		set_mode(2'h1, 1'b0);
		send5(8'hff, 8'h17, 8'h33, 8'h00, 8'h00);
		hm.frame_end();
		chk("dual cmd", 32'h1425a, {n_cmd[15:0], host_cmd_code, host_cmd_param});
		$display("commands done");
	endtask
	task automatic t_quad_dram();
		set_mode(2'h2, 1'b0);
		wr(32'h40000020, 32'haa55aa55, 32'h0f1e2d3c, 2, 0);
		rd(32'h40000020, 2);
		chk("quad word0", 32'haa55aa55, got[0]);
		chk("quad word1", 32'h0f1e2d3c, got[1]);
		wr(32'h10, 32'h11111111, 32'h22222222, 2, 0);
		rd(32'h10, 2);
		chk("quad reg word0", 32'h11111111, got[0]);
		chk("quad reg repeat", 32'h11111111, got[1]);
		set_mode(2'h0, 1'b0);
		rd(32'h14, 1);
		chk("quad reg burst", 32'h9abcdef0, got[0]);
		chk("drops", 32'h0, n_drop);
		$display("quad_dram done");
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reset, settle, then run each scenario in turn.
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (5) @(posedge ref_clk);
		t_write_read();
		t_burst_off();
		t_commands();
		t_quad_dram();
		tally_and_finish();
	end
endmodule
`default_nettype wire
